// *** verilog/sppc_top.sv ***
// Port policy control: register file, frame admission, rate limits and output FIFO
`timescale 1ns/1ps

module sppc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Fill side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  // Drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // Pointers wrap naturally since the depth is a power of two
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push != pop) count <= push ? count + 1'b1 : count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule : sppc_fifo

module sppc_top
  import sppc_pkg::*;
#(
  parameter int ACCT_PERIOD = sppc_pkg::ACCT_CYCLES
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // Wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [11:0]                  wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic [31:0]                       wb_dat_o,
  output logic                              wb_ack_o,
  // Port PHY control and negotiation results
  input  wire logic [2*sppc_pkg::N_PORTS-1:0] an_speed,
  input  wire logic [sppc_pkg::N_PORTS-1:0] an_duplex,
  output logic [sppc_pkg::N_PORTS-1:0]      port_enable,
  output logic [sppc_pkg::N_PORTS-1:0]      phy_autoneg,
  output logic [2*sppc_pkg::N_PORTS-1:0]    phy_speed,
  output logic [sppc_pkg::N_PORTS-1:0]      phy_duplex,
  output logic [sppc_pkg::N_PORTS-1:0]      pause_req,
  output logic [sppc_pkg::N_PORTS-1:0]      learn_enable,
  // Ingress frame stream
  input  wire logic                         rx_valid,
  output logic                              rx_ready,
  input  wire logic [sppc_pkg::DW-1:0]      rx_data,
  input  wire logic                         rx_last,
  input  wire logic [sppc_pkg::PW-1:0]      rx_port,
  input  wire logic [sppc_pkg::PW-1:0]      rx_dst_port,
  input  wire logic                         rx_smac_known,
  input  wire logic                         rx_bcast,
  input  wire logic                         rx_storm,
  // Egress frame stream
  output logic                              tx_valid,
  input  wire logic                         tx_ready,
  output logic [sppc_pkg::DW-1:0]           tx_data,
  output logic                              tx_last,
  output logic                              tx_err,
  output logic [sppc_pkg::PW-1:0]           tx_port,
  // System
  output logic                              sys_reboot
);
  import sppc_pkg::*;

  localparam logic [PW-1:0]     NP_V    = PW'(N_PORTS);
  localparam logic [CNT_W-1:0]  ROOM_V  = CNT_W'(FIFO_DEPTH - 2);
  localparam logic [CNT_W-1:0]  FULL_V  = CNT_W'(FIFO_DEPTH - 1);
  localparam logic [USED_W-1:0] BPS_V   = USED_W'(BYTES_PER_STEP);
  localparam logic [15:0]       TICK_W1 = 16'h0001;

  // Configuration and per-port state
  logic [CTRL_W-1:0] port_ctrl [N_PORTS];
  logic [RATE_W-1:0] ig_rate   [N_PORTS];
  logic [RATE_W-1:0] eg_rate   [N_PORTS];
  logic [N_PORTS-1:0] p_en, p_auto, p_fc, p_sec, p_storm, p_jumbo, ig_over, eg_over, dup_eff;
  logic [2*N_PORTS-1:0] spd_eff;
  logic [2*N_PORTS-1:0] an_speed_m, an_speed_q;
  logic [N_PORTS-1:0]   an_duplex_m, an_duplex_q;

  // Bus decode
  wire        wb_req   = wb_cyc_i & wb_stb_i;
  wire        wb_wr    = wb_req & wb_we_i & wb_ack_o;
  wire [PW-1:0] wb_pidx = wb_adr_i[8:4];
  wire [1:0]  wb_reg   = wb_adr_i[3:2];
  wire        wb_phit  = (wb_adr_i[11:9] == 3'h0) & (wb_pidx < NP_V) & (wb_reg != 2'h3);
  wire [31:0] wb_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        wr_cmd   = wb_wr & ({wb_adr_i[11:2], 2'h0} == GLB_CMD) & wb_sel_i[0];

  // Commands and reset tree
  logic              factory;
  logic [RBT_W-1:0]  rbt_cnt;
  logic [15:0]       drop_cnt;
  wire               cfg_rst = rst | factory;
  wire               srst    = rst | (rbt_cnt != '0);

  // Factory default is one pulse; reboot holds the datapath in reset for a fixed time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      factory    <= 1'b0;
      rbt_cnt    <= '0;
      sys_reboot <= 1'b0;
    end else begin
      factory    <= wr_cmd & wb_dat_i[CMD_FACTORY];
      rbt_cnt    <= (wr_cmd & wb_dat_i[CMD_REBOOT]) ? RBT_CYCLES :
                    (rbt_cnt != '0) ? rbt_cnt - 1'b1 : rbt_cnt;
      sys_reboot <= (wr_cmd & wb_dat_i[CMD_REBOOT]) | (rbt_cnt > 5'h01);
    end
  end

  // Negotiation results come from the PHYs, so they are synchronised first
  always_ff @(posedge core_clk) begin
    an_speed_m  <= an_speed;
    an_speed_q  <= an_speed_m;
    an_duplex_m <= an_duplex;
    an_duplex_q <= an_duplex_m;
  end

  // Accounting interval tick shared by all rate limiters
  logic [31:0] acct_cnt;
  logic        tick;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      acct_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (acct_cnt == 32'(ACCT_PERIOD - 1));
      acct_cnt <= (acct_cnt == 32'(ACCT_PERIOD - 1)) ? '0 : acct_cnt + 1'b1;
    end
  end

  // Datapath state
  sppc_state_t       state, next_state;
  logic [PW-1:0]     cur_port, cur_dst;
  logic [LEN_W-1:0]  len;
  logic              head_sop;
  logic [FW-1:0]     fifo_out;
  logic [CNT_W-1:0]  fifo_cnt;
  logic              fifo_in_ready, fifo_out_valid;
  wire               accept     = rx_valid & rx_ready;
  // The beat past the longest plain frame is marked bad, even when it closes the frame
  wire               cut_beat   = (state == SPPC_PASS) & accept &
                                  (len >= MAX_FRAME) & ~p_jumbo[cur_port];
  wire               trip       = cut_beat & ~rx_last;
  wire               fifo_push  = (state == SPPC_PASS) & accept;
  wire [PW-1:0]      head_port  = fifo_out[PW-1:0];
  wire               eg_block   = head_sop & eg_over[head_port];
  wire               out_load   = ~tx_valid | tx_ready;
  wire               fifo_pop   = fifo_out_valid & out_load & ~eg_block;
  wire               port_ok    = (rx_port < NP_V) & (rx_dst_port < NP_V);

  // Per-port configuration, status and rate accounting
  for (genvar p = 0; p < N_PORTS; p++) begin : g_port
    logic [USED_W-1:0] ig_used, eg_used;
    wire               sel_p    = wb_phit & (wb_pidx == PW'(p));
    wire [31:0]        ctrl_new = ({23'h0, port_ctrl[p]} & ~wb_mask) | (wb_dat_i & wb_mask);
    wire [31:0]        rate_new = ({3'h0, eg_rate[p], 3'h0, ig_rate[p]} & ~wb_mask) | (wb_dat_i & wb_mask);
    wire [RATE_W-1:0]  ig_new   = rate_new[RATE_W-1:0];
    wire [RATE_W-1:0]  eg_new   = rate_new[RATE_EG_LSB +: RATE_W];
    wire               wr_ctrl  = wb_wr & sel_p & (wb_reg == REG_CTRL);
    wire               wr_rate  = wb_wr & sel_p & (wb_reg == REG_RATE);

    // Speed and duplex keep their value while auto mode is selected
    always_ff @(posedge core_clk) begin
      if (cfg_rst) begin
        port_ctrl[p] <= CTRL_RST;
        ig_rate[p]   <= '0;
        eg_rate[p]   <= '0;
      end else begin
        if (wr_ctrl) begin
          port_ctrl[p] <= p_auto[p] ? {ctrl_new[CTRL_W-1:B_DUP+1], port_ctrl[p][B_DUP:B_SPD],
                                       ctrl_new[B_AUTO:B_EN]}
                                    : ctrl_new[CTRL_W-1:0];
        end
        if (wr_rate & (ig_new <= RATE_MAX)) ig_rate[p] <= ig_new;
        if (wr_rate & (eg_new <= RATE_MAX)) eg_rate[p] <= eg_new;
      end
    end

    assign p_en[p]    = port_ctrl[p][B_EN];
    assign p_auto[p]  = port_ctrl[p][B_AUTO];
    assign p_fc[p]    = port_ctrl[p][B_FC];
    assign p_sec[p]   = port_ctrl[p][B_SEC];
    assign p_storm[p] = port_ctrl[p][B_STORM];
    assign p_jumbo[p] = port_ctrl[p][B_JUMBO];
    assign spd_eff[2*p +: 2] = p_auto[p] ? an_speed_q[2*p +: 2] : port_ctrl[p][B_SPD +: 2];
    assign dup_eff[p] = p_auto[p] ? an_duplex_q[p] : port_ctrl[p][B_DUP];
    assign port_enable[p]      = p_en[p];
    assign phy_autoneg[p]      = p_auto[p];
    assign phy_speed[2*p +: 2] = port_ctrl[p][B_SPD +: 2];
    assign phy_duplex[p]       = port_ctrl[p][B_DUP];
    // A zero rate never reports an overrun, so limiting is off
    assign ig_over[p] = (ig_rate[p] != '0) & (ig_used >= USED_W'(ig_rate[p]) * BPS_V);
    assign eg_over[p] = (eg_rate[p] != '0) & (eg_used >= USED_W'(eg_rate[p]) * BPS_V);

    // Byte usage restarts every interval; saturation keeps long bursts from wrapping
    always_ff @(posedge core_clk) begin
      if (srst | tick) begin
        ig_used <= '0;
        eg_used <= '0;
      end else begin
        if (fifo_push & (cur_port == PW'(p)) & ~&ig_used) ig_used <= ig_used + 1'b1;
        if (fifo_pop & (head_port == PW'(p)) & ~&eg_used) eg_used <= eg_used + 1'b1;
      end
    end

    // Pause on overrun or on a filling buffer; learning stops on a secure port
    always_ff @(posedge core_clk) begin
      if (srst) begin
        pause_req[p]    <= 1'b0;
        learn_enable[p] <= 1'b0;
      end else begin
        pause_req[p]    <= p_fc[p] & p_en[p] & (ig_over[p] |
                           ((state == SPPC_PASS) & (cur_port == PW'(p)) & (fifo_cnt >= FULL_V)));
        learn_enable[p] <= p_en[p] & ~p_sec[p];
      end
    end

    chk_auto_locks_speed: assert property (@(posedge core_clk) disable iff (cfg_rst)
      (wr_ctrl & p_auto[p]) |=> $stable(port_ctrl[p][B_DUP:B_SPD]))
      else $error("speed or duplex changed in auto mode");
    chk_rate_range_kept: assert property (@(posedge core_clk) disable iff (cfg_rst)
      (wr_rate & (ig_new > RATE_MAX)) |=> $stable(ig_rate[p]))
      else $error("ingress rate above range was taken");
    chk_pause_on_over: assert property (@(posedge core_clk) disable iff (srst)
      (p_fc[p] & p_en[p] & ig_over[p]) |=> pause_req[p])
      else $error("no pause request on ingress overrun");
    chk_interval_clears: assert property (@(posedge core_clk) disable iff (srst)
      tick |=> (ig_used == '0) && (eg_used == '0))
      else $error("usage not cleared at interval end");
  end

  // Admission decision taken once per frame, on its first beat
  wire drop_now = ~port_ok | ~p_en[rx_port] | ~p_en[rx_dst_port] |
                  (p_sec[rx_port] & ~rx_smac_known) |
                  (p_storm[rx_port] & rx_bcast & rx_storm) |
                  (~p_fc[rx_port] & (ig_over[rx_port] | (fifo_cnt >= FULL_V)));
  wire room     = (fifo_cnt <= ROOM_V);
  wire fc_stall = p_fc[cur_port] & ig_over[cur_port];

  // Frame state machine
  always_comb begin
    next_state = state;
    case (state)
      SPPC_IDLE: if (rx_valid) next_state = drop_now ? SPPC_DROP : SPPC_PASS;
      SPPC_PASS: begin
        if (accept & rx_last) next_state = SPPC_IDLE;
        else if (trip) next_state = SPPC_DROP;
      end
      SPPC_DROP: if (accept & rx_last) next_state = SPPC_IDLE;
      default: next_state = SPPC_IDLE;
    endcase
  end

  // Ready is registered, so for a passed frame it only opens while two FIFO words are still free
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state    <= SPPC_IDLE;
      rx_ready <= 1'b0;
      cur_port <= '0;
      cur_dst  <= '0;
      len      <= '0;
      drop_cnt <= '0;
    end else begin
      state    <= next_state;
      rx_ready <= (next_state == SPPC_DROP) | ((next_state == SPPC_PASS) & room & ~fc_stall);
      if (state == SPPC_IDLE) begin
        cur_port <= rx_port;
        cur_dst  <= rx_dst_port;
      end
      len      <= (state == SPPC_IDLE) ? '0 : (accept & ~&len) ? len + 1'b1 : len;
      if ((state != SPPC_DROP) & (next_state == SPPC_DROP)) drop_cnt <= drop_cnt + TICK_W1;
    end
  end

  sppc_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (srst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({rx_data, rx_last | cut_beat, cut_beat, cur_dst}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out),
    .count     (fifo_cnt)
  );

  // Output register; a frame start waits while its egress budget is spent
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_valid <= 1'b0;
      tx_data  <= '0;
      tx_last  <= 1'b0;
      tx_err   <= 1'b0;
      tx_port  <= '0;
      head_sop <= 1'b1;
    end else begin
      if (out_load) tx_valid <= fifo_pop;
      if (fifo_pop) begin
        {tx_data, tx_last, tx_err, tx_port} <= fifo_out;
        head_sop <= fifo_out[PW+1];
      end
    end
  end

  // Register read mux
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0;
    if (wb_phit) begin
      case (wb_reg)
        REG_CTRL: rd_data = {23'h0, port_ctrl[wb_pidx]};
        REG_RATE: rd_data = {3'h0, eg_rate[wb_pidx], 3'h0, ig_rate[wb_pidx]};
        REG_STAT: rd_data = {26'h0, eg_over[wb_pidx], ig_over[wb_pidx], pause_req[wb_pidx],
                             dup_eff[wb_pidx], spd_eff[2*wb_pidx +: 2]};
        default:  rd_data = 32'h0;
      endcase
    end else if ({wb_adr_i[11:2], 2'h0} == GLB_STAT) begin
      rd_data = {drop_cnt, 11'h0, state, fifo_cnt};
    end
  end

  // Every access is answered one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req & ~wb_ack_o) wb_dat_o <= rd_data;
    end
  end

  chk_ack_single_pulse: assert property (@(posedge core_clk) disable iff (rst)
    wb_ack_o |=> ~wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_disabled_port_drop: assert property (@(posedge core_clk) disable iff (srst)
    ((state == SPPC_IDLE) & rx_valid & port_ok & ~p_en[rx_port]) |=> (state == SPPC_DROP))
    else $error("frame from disabled port admitted");
  chk_nofc_over_drop: assert property (@(posedge core_clk) disable iff (srst)
    ((state == SPPC_IDLE) & rx_valid & port_ok & ~p_fc[rx_port] & ig_over[rx_port]) |=> (state == SPPC_DROP))
    else $error("frame over limit admitted without flow control");
  chk_secure_unknown_drop: assert property (@(posedge core_clk) disable iff (srst)
    ((state == SPPC_IDLE) & rx_valid & port_ok & p_sec[rx_port] & ~rx_smac_known) |=> (state == SPPC_DROP))
    else $error("unknown source admitted on secure port");
  chk_fc_backpressure: assert property (@(posedge core_clk) disable iff (srst)
    ((state == SPPC_PASS) & fc_stall & (next_state == SPPC_PASS)) |=> ~rx_ready)
    else $error("ingress not stalled over limit");
  chk_oversize_cut: assert property (@(posedge core_clk) disable iff (srst)
    trip |=> (state == SPPC_DROP) && (fifo_cnt != '0))
    else $error("oversize frame not cut");
  chk_fifo_no_overflow: assert property (@(posedge core_clk) disable iff (srst)
    fifo_push |-> fifo_in_ready)
    else $error("push into a full buffer");
  sequence reboot_cmd_s;
    wr_cmd & wb_dat_i[CMD_REBOOT];
  endsequence
  sequence reboot_hold_s;
    sys_reboot & srst;
  endsequence
  chk_reboot_pulse: assert property (@(posedge core_clk) disable iff (rst)
    reboot_cmd_s |=> reboot_hold_s [*8])
    else $error("reboot pulse too short");
  chk_factory_restore: assert property (@(posedge core_clk) disable iff (rst)
    (wr_cmd & wb_dat_i[CMD_FACTORY]) |=> ##1 (port_ctrl[0] == CTRL_RST) && (ig_rate[0] == '0))
    else $error("factory default not restored");
endmodule : sppc_top

// *** verilog/sppc_pkg.sv ***
// Shared constants and types for the switch port policy control block
package sppc_pkg;
  // Structure
  localparam int N_PORTS    = 24;
  localparam int PW         = 5;
  localparam int DW         = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int FW         = DW + 2 + PW;            // data, last, err, destination port
  localparam int RATE_W     = 13;
  localparam int USED_W     = 18;
  localparam int LEN_W      = 14;
  localparam int CTRL_W     = 9;
  localparam int RBT_W      = 5;
  localparam int CNT_W      = 3;

  // Rate accounting: 128 kbit/s per step, counted in bytes over a fixed interval
  localparam int STEP_BPS        = 128000;
  localparam int ACCT_US         = 1000;
  localparam int CLK_HZ          = 20000000;
  localparam int ACCT_CYCLES     = CLK_HZ / 1000000 * ACCT_US;
  localparam int BYTES_PER_STEP  = STEP_BPS / 8 * ACCT_US / 1000000;
  localparam logic [RATE_W-1:0] RATE_MAX = 13'h1f40;  // 8000 steps
  localparam logic [LEN_W-1:0]  MAX_FRAME = 14'h05ee; // 1518 bytes without jumbo
  localparam logic [RBT_W-1:0]  RBT_CYCLES = 5'h10;   // Length of the soft reset pulse

  // Register map (byte addresses); per port block of 16 bytes at port * 16
  localparam logic [1:0]  REG_CTRL = 2'h0;
  localparam logic [1:0]  REG_RATE = 2'h1;
  localparam logic [1:0]  REG_STAT = 2'h2;
  localparam logic [11:0] GLB_CMD  = 12'h400;
  localparam logic [11:0] GLB_STAT = 12'h404;

  // Control word fields
  localparam int B_EN    = 0;
  localparam int B_AUTO  = 1;
  localparam int B_SPD   = 2;                         // Two bits: 0 = 10M, 1 = 100M, 2 = 1000M
  localparam int B_DUP   = 4;
  localparam int B_FC    = 5;
  localparam int B_SEC   = 6;
  localparam int B_STORM = 7;
  localparam int B_JUMBO = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h01b;   // Enabled, auto, 1000M, full duplex
  localparam int RATE_EG_LSB = 16;

  // Command word fields
  localparam int CMD_FACTORY = 0;
  localparam int CMD_REBOOT  = 1;

  typedef enum logic [1:0] {SPPC_IDLE, SPPC_PASS, SPPC_DROP} sppc_state_t;
endpackage : sppc_pkg

// *** bench/sppc_partner.sv ***
// Link partner model: negotiated PHY results and a stalling egress sink
`timescale 1ns/1ps
module sppc_partner import sppc_pkg::*; (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // PHY results
  output logic [2*sppc_pkg::N_PORTS-1:0] an_speed,
  output logic [sppc_pkg::N_PORTS-1:0]   an_duplex,
  // Egress sink and stall request
  input  wire logic                      tx_valid,
  output logic                           tx_ready,
  input  wire logic [sppc_pkg::DW-1:0]   tx_data,
  input  wire logic                      tx_err,
  input  wire logic                      hold
);
  import sppc_pkg::*;
  logic [DW-1:0] got[$];
  int            errs;
  // Fixed per-port results so that neighbouring ports differ
  always_comb begin
    for (int p = 0; p < N_PORTS; p++) begin
      an_speed[2*p+:2] = 2'(p % 3);
      an_duplex[p] = 1'(p % 2);
    end
  end
  // Random stalls prove that no beat is lost under backpressure
  always_ff @(posedge core_clk) begin
    tx_ready <= !rst && !hold && ($urandom_range(3) != 0);
    if (!rst && tx_valid && tx_ready) begin
      got.push_back(tx_data);
      errs <= errs + int'(tx_err);
    end
  end
endmodule : sppc_partner

// *** bench/switch_port_policy_control_tb.sv ***
// Bench for the port policy block: bus tasks, frame driver and byte model
`timescale 1ns/1ps
module switch_port_policy_control_tb;
  import sppc_pkg::*;
  logic core_clk, rst, cyc, stb, we, hold, ack, rx_valid, rx_ready, rx_last;
  logic tx_valid, tx_ready, tx_err, rx_known, rx_bcast, rx_storm, sys_reboot;
  logic [11:0] adr;
  logic [31:0] dat, dat_o, q;
  logic [DW-1:0] rx_data, tx_data;
  logic [PW-1:0] rx_port;
  logic [2*N_PORTS-1:0] an_speed, phy_speed;
  logic [N_PORTS-1:0] an_duplex, port_enable, learn_enable, pause_req;
  logic [7:0] exp_q[$];
  int fail_count, checks_done, n;
  sppc_top #(.ACCT_PERIOD(100)) DUT (.core_clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .an_speed,
    .an_duplex, .port_enable, .phy_autoneg(), .phy_speed, .phy_duplex(), .pause_req, .learn_enable,
    .rx_valid, .rx_ready, .rx_data, .rx_last, .rx_port, .rx_dst_port(5'h01), .rx_smac_known(rx_known),
    .rx_bcast, .rx_storm, .tx_valid, .tx_ready, .tx_data, .tx_last(), .tx_err, .tx_port(), .sys_reboot);
  sppc_partner lp (.core_clk, .rst, .an_speed, .an_duplex, .tx_valid, .tx_ready, .tx_data, .tx_err, .hold);
  // Clock at 20 MHz
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  task end_of_test;
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task check(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : check
  // Classic cycle; the edge that sees ack both applies a write and yields read data
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    for (k = 0; k < 50 && ack !== 1'b1; k++) @(posedge core_clk);
    if (k == 50) begin fail_count++; end_of_test(); end
    q = dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask : wb
  // One byte per beat; the first keep bytes are expected at egress
  task send(input int p, input int len, input logic [2:0] f, input int keep);
    logic [7:0] b;
    int k;
    for (int i = 0; i < len; i++) begin
      b = 8'($urandom);
      if (i < keep) exp_q.push_back(b);
      {rx_valid, rx_data, rx_last, rx_port} <= {1'b1, b, i == len - 1, 5'(p)};
      {rx_bcast, rx_storm, rx_known} <= f;
      for (k = 0; k < 400; k++) begin @(posedge core_clk); if (rx_ready === 1'b1) break; end
      if (k == 400) begin fail_count++; end_of_test(); end
    end
    {rx_valid, rx_last} <= 2'b00;
    @(posedge core_clk);
  endtask : send
  task drain(input int extra);
    for (n = 0; n < 5000 && lp.got.size() != exp_q.size() + extra; n++) @(posedge core_clk);
    if (n == 5000) begin fail_count++; end_of_test(); end
    repeat (20) @(posedge core_clk);
    check("tx beats", 32'(exp_q.size() + extra), 32'(lp.got.size()));
    foreach (exp_q[i]) check("tx byte", 32'(exp_q[i]), 32'(lp.got[i]));
    exp_q.delete();
    lp.got.delete();
  endtask : drain
  initial begin
    {cyc, stb, we, adr, dat, hold, rx_valid, rx_data, rx_last, rx_port} = '0;
    {rx_known, rx_bcast, rx_storm} = 3'b000;
    rst = 1;
    void'($urandom(43568));
    repeat (8) @(posedge core_clk);
    rst <= 0;
    // Auto mode ignores speed writes and reports negotiated results
    wb(1, 12'h020, 32'h003); wb(0, 12'h020, 0); check("ctrl", 32'h01b, q);
    wb(0, 12'h028, 0); check("stat", 32'h2, q & 7);
    // Speed stays locked until auto is off, so leave auto first, then force 100M half
    wb(1, 12'h020, 32'h001); wb(1, 12'h020, 32'h005);
    wb(0, 12'h028, 0); check("stat", 32'h1, q & 7);
    check("phy speed", 1, phy_speed[5:4]);
    // Rates: over-range halves are ignored, ports independent
    wb(1, 12'h034, {16'd8001, 16'd8000}); wb(1, 12'h034, {16'd1, 16'd8001});
    wb(0, 12'h034, 0); check("rate", 32'h00011f40, q);
    wb(0, 12'h044, 0); check("rate", 0, q);
    wb(0, 12'h7f0, 0); check("unmapped", 0, q);
    // Secure, storm filter and disabled ports
    wb(1, 12'h060, 32'h05b); wb(1, 12'h070, 32'h01a); repeat (2) @(posedge core_clk);
    check("learn", 0, learn_enable[6]);
    check("enable", 0, port_enable[7]);
    send(0, 5, 3'b111, 5); wb(1, 12'h000, 32'h09b);
    send(0, 5, 3'b111, 0); send(0, 5, 3'b101, 5); send(7, 4, 3'b001, 0);
    send(6, 4, 3'b000, 0); send(6, 4, 3'b001, 4);
    wb(1, 12'h010, 32'h01a); send(0, 4, 3'b001, 0); wb(1, 12'h010, 32'h01b);
    drain(0);
    // Oversize cut with an error beat, jumbo passes whole
    send(0, 1520, 3'b001, 1518); drain(1); check("err beats", 1, lp.errs);
    wb(1, 12'h000, 32'h19b); send(0, 1520, 3'b001, 1520); drain(0);
    // Stalled sink lets the FIFO fill
    hold <= 1;
    fork
      send(0, 8, 3'b001, 8);
      begin repeat (40) @(posedge core_clk); wb(0, GLB_STAT, 0); hold <= 0; end
    join
    check("fifo full", 1, q[2:0] >= 3'h3); drain(0);
    wb(1, GLB_CMD, 32'h1); repeat (3) @(posedge core_clk);
    wb(0, 12'h000, 0); check("ctrl", 32'h01b, q);
    wb(0, 12'h034, 0); check("rate", 0, q);
    // One step per interval on port 0: flow control stalls the frame and raises pause
    wb(1, 12'h000, 32'h03b); wb(1, 12'h004, 32'h1); n = 0;
    fork
      send(0, 40, 3'b001, 40);
      repeat (200) begin @(posedge core_clk); n += int'(pause_req[0] === 1'b1); end
    join
    check("pause seen", 1, n > 0); drain(0);
    wb(1, GLB_CMD, 32'h2); n = 0;
    repeat (40) begin @(posedge core_clk); n += int'(sys_reboot === 1'b1); end
    check("reboot cycles", 16, n);
    end_of_test();
  end
endmodule : switch_port_policy_control_tb
